// ---- eeprom_pkg.sv ----
// Package with constants and carriers for the EEPROM page latch programmer
package eeprom_pkg;
    localparam int ADDR_W        = 11;                // EEPROM byte address
    localparam int ROW_W         = 4;                 // Row select bits
    localparam int COL_W         = 7;                 // Column select bits
    localparam int PAGE_BYTES    = 128;               // Column latch size
    localparam int DATA_W        = 8;                 // Byte width
    localparam int XADDR_W       = 16;                // External data address
    localparam logic [15:0] EE_LAST_ADDR = 16'h07FF;  // Top of EEPROM range
    // APB register offsets
    localparam logic [11:0] OFS_CONTROL  = 12'h000;   // eeprom_control_reg
    localparam logic [11:0] OFS_STATUS   = 12'h004;   // Sticky events
    localparam logic [11:0] OFS_MASK     = 12'h008;   // Interrupt mask
    // Control register fields
    localparam int BIT_BUSY      = 0;                 // eeprom_busy_flag
    localparam int BIT_MAP       = 1;                 // eeprom_map_enable
    localparam int LAUNCH_LSB    = 4;                 // program_launch_field
    localparam logic [3:0] LAUNCH_FIRST  = 4'h5;      // First unlock nibble
    localparam logic [3:0] LAUNCH_SECOND = 4'hA;      // Second unlock nibble
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    // Status event bits
    localparam int EV_DONE       = 0;                 // Programming finished
    localparam int EV_ABORT      = 1;                 // Unlock aborted
    localparam int EV_W          = 2;
    // Row programming time
    localparam int PROG_TIME_US  = 10;                // Time per row
    localparam int CLK_MHZ       = 100;
    localparam int PROG_CYCLES   = PROG_TIME_US * CLK_MHZ;

    // One external data move from the CPU
    typedef struct packed {
        logic                 valid;   // Move strobe, one cycle
        logic                 write;   // 1 write, 0 read
        logic [XADDR_W-1:0]   addr;    // data_pointer value
        logic [DATA_W-1:0]    wdata;   // Byte to write
    } xmove_s;

    // Programming FSM states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ARMED = 2'b01,
        ST_PROG  = 2'b10
    } prog_state_e;
endpackage

// ---- eeprom_array.sv ----
// Row-organised EEPROM storage with registered read data
`timescale 1ns/1ns
module eeprom_array
    import eeprom_pkg::*;
#(
    parameter int DEPTH = 2048,
    parameter int AW    = 11
)
(
    input  wire logic          ref_clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [7:0]    rdata
);
    logic [7:0] mem [DEPTH];   // Cell array, no reset (nonvolatile)

    // One byte written per cycle while a row is programmed
    always_ff @(posedge ref_clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    // Registered read port
    always_ff @(posedge ref_clk)
    begin
        rdata <= mem[raddr];
    end
endmodule

// ---- eeprom_page_latch_programmer.sv ----
// EEPROM column latch, row programming and APB control top level
// Operation
// - 2KB EEPROM at 0000h-07FFh while mapped
// - Mapping only via control register bits
// - Mapped read returns stored EEPROM byte
// - Write: load latches, then program row
// - One to 128 latched bytes per page
// - Per-byte flag; only flagged bytes programmed
// - Clear all flags after row finishes
// - Upper 4 bits row, lower 7 column
// - Mapped write stores byte in latch unless busy
// - Last latch write's page is programmed
// - 50h then A0h starts programming
// - Busy set at start; EEPROM unreadable
// - Hardware clears busy when row completes
// - Other instruction between unlock writes aborts
// - 02h maps, 00h unmaps EEPROM
`timescale 1ns/1ns
module eeprom_page_latch_programmer
    import eeprom_pkg::*;
#(
    parameter int PROG_COUNT = PROG_CYCLES   // Cycles per row programming
)
(
    input  wire logic                ref_clk,
    input  wire logic                resetn,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // CPU external data moves
    input  wire xmove_s              xmove,
    input  wire logic                cpu_instr,  // One pulse per instruction
    output logic      [DATA_W-1:0]   xrdata,     // EEPROM read data
    output logic                     xrvalid,    // Read data valid pulse
    output logic                     aux_data_ram_sel,   // Move routed to aux_data_ram
    output logic                     irq
);
    // Control register bits
    logic              eeprom_map_enable;        // Route moves to EEPROM
    logic              eeprom_busy_flag;         // Row programming running
    logic [3:0]        program_launch_field;     // Last launch nibble
    prog_state_e       state;                    // Launch/program FSM
    // Column latch
    logic [7:0]        latch_data [PAGE_BYTES];  // Column latch bytes
    logic [PAGE_BYTES-1:0] latch_flag;           // Ninth bits
    logic [ROW_W-1:0]  prog_row;                 // Row to program
    logic [COL_W-1:0]  prog_col;                 // Column being programmed
    logic [15:0]       prog_timer;               // Row programming timer
    // Interrupt
    logic [EV_W-1:0]   ev_status;                // Sticky events
    logic [EV_W-1:0]   ev_mask;                  // Mask, 1 enables
    logic [EV_W-1:0]   ev_set;                   // Event pulses
    // Array port
    logic              arr_we;
    logic [ADDR_W-1:0] arr_waddr;
    logic [ADDR_W-1:0] arr_raddr;
    logic [7:0]        arr_rdata;
    logic              rd_pend;                  // Read issued last cycle

    // Address in EEPROM window
    function automatic logic in_range(input logic [XADDR_W-1:0] a);
        in_range = (a <= EE_LAST_ADDR);
    endfunction

    // APB decode helpers
    logic apb_wr;
    logic apb_rd;
    logic ctrl_wr;
    logic ee_hit;
    logic ee_wr;
    logic ee_rd;
    logic [7:0] ctrl_byte;
    assign apb_wr    = psel && penable && pwrite;
    assign apb_rd    = psel && penable && !pwrite;
    assign ctrl_wr   = apb_wr && (paddr == OFS_CONTROL);
    assign ctrl_byte = pwdata[7:0];
    // Moves claimed by the EEPROM only while mapped
    assign ee_hit    = xmove.valid && eeprom_map_enable
                       && in_range(xmove.addr);
    assign ee_wr     = ee_hit && xmove.write;
    // Reads blocked while busy
    assign ee_rd     = ee_hit && !xmove.write
                       && !eeprom_busy_flag;
    // Everything else goes to the normal memory
    assign aux_data_ram_sel  = xmove.valid && !ee_hit;
    assign pready    = 1'b1;                                // Zero wait states
    assign pslverr   = 1'b0;

    // Map enable written by the control register
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            eeprom_map_enable <= CONTROL_RESET[BIT_MAP];
        end
        else if (ctrl_wr)
        begin
            eeprom_map_enable <= ctrl_byte[BIT_MAP];
        end
    end

    // Launch sequencer and row programming
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            state                <= ST_IDLE;
            program_launch_field <= 4'h0;
            eeprom_busy_flag     <= 1'b0;
            prog_col             <= '0;
            prog_timer           <= '0;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                begin
                    // First unlock write
                    if (ctrl_wr
                        && ctrl_byte[7:LAUNCH_LSB] == LAUNCH_FIRST)
                    begin
                        state                <= ST_ARMED;
                        program_launch_field <= LAUNCH_FIRST;
                    end
                end
                ST_ARMED:
                begin
                    // Second unlock write must be the next instruction
                    if (ctrl_wr
                        && ctrl_byte[7:LAUNCH_LSB] == LAUNCH_SECOND)
                    begin
                        state                <= ST_PROG;
                        program_launch_field <= LAUNCH_SECOND;
                        eeprom_busy_flag     <= 1'b1;
                        prog_col             <= '0;
                        prog_timer           <= '0;
                    end
                    else if (ctrl_wr || cpu_instr)
                    begin
                        state                <= ST_IDLE;
                        program_launch_field <= 4'h0;
                    end
                end
                ST_PROG:
                begin
                    // Step columns, then wait out the row time
                    if (prog_col != COL_W'(PAGE_BYTES - 1))
                    begin
                        prog_col <= prog_col + 1'b1;
                    end
                    if (prog_timer == 16'(PROG_COUNT - 1))
                    begin
                        state                <= ST_IDLE;
                        eeprom_busy_flag     <= 1'b0;
                        program_launch_field <= 4'h0;
                    end
                    else
                    begin
                        prog_timer <= prog_timer + 1'b1;
                    end
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Done / abort events
    assign ev_set[EV_DONE]  = (state == ST_PROG)
                              && (prog_timer == 16'(PROG_COUNT - 1));
    assign ev_set[EV_ABORT] = (state == ST_ARMED) && (ctrl_wr || cpu_instr)
                              && !(ctrl_wr
                                   && ctrl_byte[7:LAUNCH_LSB]
                                      == LAUNCH_SECOND);

    // Column latch bytes; writes while busy are dropped to protect the row
    genvar gi;
    generate
        for (gi = 0; gi < PAGE_BYTES; gi++)
        begin : g_latch
            always_ff @(posedge ref_clk)
            begin
                if (!resetn)
                begin
                    latch_data[gi] <= 8'h00;
                end
                else if (ee_wr && !eeprom_busy_flag
                         && xmove.addr[COL_W-1:0] == COL_W'(gi))
                begin
                    latch_data[gi] <= xmove.wdata;
                end
            end
        end
    endgenerate

    // Ninth bits: set on byte write, cleared at row end
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            latch_flag <= '0;
        end
        else if (ev_set[EV_DONE])
        begin
            latch_flag <= '0;
        end
        else if (ee_wr && !eeprom_busy_flag)
        begin
            latch_flag[xmove.addr[COL_W-1:0]] <= 1'b1;
        end
    end

    // Row follows the last latch write
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            prog_row <= '0;
        end
        else if (ee_wr && !eeprom_busy_flag)
        begin
            prog_row <= xmove.addr[ADDR_W-1:COL_W];
        end
    end

    // Only flagged bytes reach the array; the rest of the row is untouched
    assign arr_we    = (state == ST_PROG) && (prog_timer < 16'(PAGE_BYTES))
                       && latch_flag[prog_col];
    assign arr_waddr = {prog_row, prog_col};
    assign arr_raddr = xmove.addr[ADDR_W-1:0];

    eeprom_array #(
        .DEPTH (PAGE_BYTES * (1 << ROW_W)),
        .AW    (ADDR_W)
    ) u_array (
        .ref_clk (ref_clk),
        .we      (arr_we),
        .waddr   (arr_waddr),
        .wdata   (latch_data[prog_col]),
        .raddr   (arr_raddr),
        .rdata   (arr_rdata)
    );

    // Read data one cycle after the move
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            rd_pend <= 1'b0;
        end
        else
        begin
            rd_pend <= ee_rd;
        end
    end

    // Returned byte held until next read
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            xrdata  <= 8'h00;
            xrvalid <= 1'b0;
        end
        else
        begin
            xrvalid <= rd_pend;
            if (rd_pend)
            begin
                xrdata <= arr_rdata;
            end
        end
    end

    // Sticky status, set wins over write-one-clear
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            ev_status <= '0;
        end
        else
        begin
            ev_status <= (ev_status
                          & ~((apb_wr && paddr == OFS_STATUS)
                              ? pwdata[EV_W-1:0] : '0))
                         | ev_set;
        end
    end

    // Interrupt mask
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            ev_mask <= '0;
        end
        else if (apb_wr && paddr == OFS_MASK)
        begin
            ev_mask <= pwdata[EV_W-1:0];
        end
    end

    assign irq = |(ev_status & ev_mask);

    // APB read mux, combinational over registered state
    always_comb
    begin
        prdata = 32'h0000_0000;
        if (apb_rd)
        begin
            unique case (paddr)
                OFS_CONTROL:
                    prdata = {24'h000000, program_launch_field, 2'b00,
                              eeprom_map_enable, eeprom_busy_flag};
                OFS_STATUS: prdata = {30'h0, ev_status};
                OFS_MASK:   prdata = {30'h0, ev_mask};
                default:    prdata = 32'h0000_0000;
            endcase
        end
    end
endmodule

// ---- eeprom_page_latch_programmer_monitor.sv ----
// Port checker for the EEPROM page latch programmer, bound to the top
`timescale 1ns/1ns
module eeprom_monitor
    import eeprom_pkg::*;
#(
    parameter int PROG_COUNT = PROG_CYCLES
)
(
    input wire logic        ref_clk,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire xmove_s      xmove,
    input wire logic        cpu_instr,
    input wire logic [7:0]  xrdata,
    input wire logic        xrvalid,
    input wire logic        aux_data_ram_sel,
    input wire logic        irq
);
    wire ctl_wr = psel && penable && pwrite && paddr == OFS_CONTROL;
    wire ctl_rd = psel && penable && !pwrite && paddr == OFS_CONTROL;
    wire ee_rd  = xmove.valid && !xmove.write;
    logic map_h;    // Shadow of the map bit
    logic armed;    // First unlock write seen
    int   cnt;      // Programming cycles left
    // Map shadow follows every control write
    always_ff @(posedge ref_clk)
        if (!resetn) map_h <= 1'b0;
        else if (ctl_wr) map_h <= pwdata[BIT_MAP];
    // Any instruction in between drops the arming; a second first-unlock
    // write while armed breaks the pair instead of re-arming
    always_ff @(posedge ref_clk)
        if (!resetn) armed <= 1'b0;
        else if (ctl_wr)
            armed <= !armed && pwdata[7:4] == LAUNCH_FIRST && cnt == 0;
        else if (cpu_instr) armed <= 1'b0;
    // Busy window model
    always_ff @(posedge ref_clk)
        if (!resetn) cnt <= 0;
        else if (ctl_wr && armed && pwdata[7:4] == LAUNCH_SECOND)
            cnt <= PROG_COUNT;
        else if (cnt != 0) cnt <= cnt - 1;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    a_move_route: assert property (
        xmove.valid |-> aux_data_ram_sel == (!map_h || xmove.addr > EE_LAST_ADDR))
        else $error("move route");
    a_route_idle: assert property (!xmove.valid |-> !aux_data_ram_sel)
        else $error("route without move");
    a_read_answer: assert property (ee_rd && !aux_data_ram_sel && cnt == 0
        |-> ##2 xrvalid) else $error("mapped read unanswered");
    a_rdvalid_cause: assert property (xrvalid |->
        $past(ee_rd && !aux_data_ram_sel, 2)) else $error("stray read valid");
    a_unmapped_read: assert property (
        ee_rd && aux_data_ram_sel |-> ##2 !xrvalid)
        else $error("unmapped read answered");
    a_busy_refuse: assert property (
        ee_rd && cnt != 0 |-> ##2 !xrvalid)
        else $error("read while busy answered");
    a_busy_flag: assert property (
        ctl_rd |-> prdata[BIT_BUSY] == (cnt != 0))
        else $error("busy flag wrong");
    a_launch_field: assert property (
        ctl_rd |-> prdata[7:4] == (armed ? LAUNCH_FIRST
                                   : cnt != 0 ? LAUNCH_SECOND : 4'h0))
        else $error("launch field wrong");
    a_map_readback: assert property (
        ctl_rd |-> prdata[BIT_MAP] == map_h)
        else $error("map bit wrong");
    // Every APB access must always complete without an error response
    a_bus_answer: assert property (
        psel && penable |-> pready && !pslverr)
        else $error("bus access not answered cleanly");
    c_launch: cover property (ctl_wr && armed && pwdata[7:4] == LAUNCH_SECOND);
    c_busy_read: cover property (ee_rd && cnt != 0);
    c_read_data: cover property (xrvalid);
endmodule
bind eeprom_page_latch_programmer eeprom_monitor #(.PROG_COUNT(PROG_COUNT)) mon
(
    .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .xmove(xmove), .cpu_instr(cpu_instr),
    .xrdata(xrdata), .xrvalid(xrvalid), .aux_data_ram_sel(aux_data_ram_sel), .irq(irq)
);

// ---- cpu_move_model.sv ----
// Behavioural CPU core issuing external data moves and instruction pulses
`timescale 1ns/1ns
module cpu_move_model
    import eeprom_pkg::*;
(
    input  wire logic ref_clk,
    output xmove_s    xmove,
    output logic      cpu_instr
);
    initial
    begin
        xmove     = '0;
        cpu_instr = 1'b0;
    end
    // One move; caller keeps interrupts off and maps first
    // Page changes between launches only when a scenario asks
    task automatic move(input logic w, input logic [15:0] a,
                        input logic [7:0] d);
        @(posedge ref_clk);
        xmove     <= '{1'b1, w, a, d};
        cpu_instr <= 1'b1;
        @(posedge ref_clk);
        // Released lines toggle so stale values never look valid
        xmove     <= '{1'b0, ~w, ~a, ~d};
        cpu_instr <= 1'b0;
    endtask
    // Instruction with no data move, used to break the unlock pair
    task automatic instr();
        @(posedge ref_clk);
        cpu_instr <= 1'b1;
        @(posedge ref_clk);
        cpu_instr <= 1'b0;
    endtask
endmodule

// ---- eeprom_page_latch_programmer_tb.sv ----
// Self-checking testbench for the EEPROM page latch programmer
`timescale 1ns/1ns
module eeprom_page_latch_programmer_tb
    import eeprom_pkg::*;
;
    localparam int PCNT = 200;  // Short row time keeps the run brief
    logic        ref_clk, resetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic        pready, pslverr, cpu_instr, xrvalid, aux_data_ram_sel, irq, v;
    logic [7:0]  xrdata, d;
    xmove_s      xmove;
    int          n_mismatch, tests_run;
    eeprom_page_latch_programmer #(.PROG_COUNT(PCNT)) uut
    (
        .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .xmove(xmove),
        .cpu_instr(cpu_instr), .xrdata(xrdata), .xrvalid(xrvalid),
        .aux_data_ram_sel(aux_data_ram_sel), .irq(irq)
    );
    cpu_move_model cpu
    (
        .ref_clk(ref_clk), .xmove(xmove), .cpu_instr(cpu_instr)
    );
    // Free-running 100 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim();
        if (n_mismatch == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // APB transfer: setup, then access held until pready is seen
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] r);
        @(posedge ref_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            r = prdata;
        end
        while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        logic [31:0] junk;
        apb(1'b1, a, wd, junk);
    endtask
    // Read move; answer lands two sampled edges after the move
    task automatic ee_read(input logic [15:0] a);
        cpu.move(1'b0, a, 8'h00);
        @(posedge ref_clk);
        #1;
        v = xrvalid;
        d = xrdata;
    endtask
    // Unlock pair, refused read while busy, wait for hardware to finish
    task automatic launch_wait();
        wr(OFS_CONTROL, 32'h50);
        wr(OFS_CONTROL, 32'hA0);
        apb(1'b0, OFS_CONTROL, 32'h0, rv);
        check("busy set", rv, 32'hA1);
        wr(OFS_CONTROL, 32'h02);
        ee_read(16'h0280);
        check("busy read", v, 1'b0);
        for (int i = 0; i < 400 && rv[BIT_BUSY] !== 1'b0; i++)
            apb(1'b0, OFS_CONTROL, 32'h0, rv);
        check("busy clear", rv, 32'h02);
        check("done irq", irq, 1'b1);
        apb(1'b0, OFS_STATUS, 32'h0, rv);
        check("done event", rv, 32'h1);
        wr(OFS_STATUS, 32'h1);
        // Clear lands at the access edge; look once it has settled
        #1;
        check("irq cleared", irq, 1'b0);
    endtask
    // Mapping on and off, out-of-range and unmapped reads
    task automatic t_map();
        wr(OFS_CONTROL, 32'h02);
        apb(1'b0, OFS_CONTROL, 32'h0, rv);
        check("map set", rv, 32'h02);
        ee_read(16'h0800);
        check("out of range", v, 1'b0);
        wr(OFS_CONTROL, 32'h00);
        apb(1'b0, OFS_CONTROL, 32'h0, rv);
        check("map clear", rv, 32'h00);
        ee_read(16'h0005);
        check("unmapped read", v, 1'b0);
    endtask
    // Pages mixed on purpose: last page wins, column edges kept
    task automatic t_program();
        wr(OFS_MASK, 32'h1);
        wr(OFS_CONTROL, 32'h02);
        cpu.move(1'b1, 16'h0180, 8'hA5);
        cpu.move(1'b1, 16'h02FF, 8'h3C);
        cpu.move(1'b1, 16'h0280, 8'hC3);
        launch_wait();
        ee_read(16'h0280);
        check("row byte col0", {v, d}, 9'h1C3);
        ee_read(16'h02FF);
        check("row byte col127", {v, d}, 9'h13C);
        ee_read(16'h0180);
        check("discarded page", d === 8'hA5, 1'b0);
    endtask
    // One byte only: stale latch data must not reach the new row
    task automatic t_flags();
        cpu.move(1'b1, 16'h0201, 8'h5A);
        launch_wait();
        ee_read(16'h0201);
        check("single byte", {v, d}, 9'h15A);
        ee_read(16'h0200);
        check("flag cleared", d === 8'hC3, 1'b0);
        ee_read(16'h0280);
        check("other row kept", {v, d}, 9'h1C3);
    endtask
    // Broken unlock pair, with and without the abort mask
    task automatic t_abort();
        wr(OFS_MASK, 32'h2);
        wr(OFS_CONTROL, 32'h50);
        apb(1'b0, OFS_CONTROL, 32'h0, rv);
        check("armed field", rv, 32'h50);
        cpu.instr();
        wr(OFS_CONTROL, 32'hA0);
        apb(1'b0, OFS_CONTROL, 32'h0, rv);
        check("aborted launch", rv, 32'h00);
        check("abort irq", irq, 1'b1);
        wr(OFS_STATUS, 32'h2);
        wr(OFS_MASK, 32'h0);
        wr(OFS_CONTROL, 32'h50);
        wr(OFS_CONTROL, 32'h00);
        apb(1'b0, OFS_STATUS, 32'h0, rv);
        check("abort event", rv, 32'h2);
        check("masked irq", irq, 1'b0);
    endtask
    // Watchdog: whole run needs well under 5000 cycles
    initial
    begin
        #200000;
        n_mismatch++;
        end_sim();
    end
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        resetn = 1'b0;
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        t_map();
        t_program();
        t_flags();
        t_abort();
        end_sim();
    end
endmodule
